// ===== verilog/lpm_consts.svh
// lpm_consts: offsets, field positions and reset values of the power-mode block
// assumes inclusion by bare name from the design files
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
// register indices, byte address is four times the index
`define LPM_IDX_POWER_CONTROL 10'h087
`define LPM_IDX_PORT1_MODE_SELECT_TWO 10'h0B4
`define LPM_IDX_STAT 10'h0C0
// power control fields
`define LPM_BIT_IDL 0
`define LPM_BIT_PD 1
`define LPM_POWER_CONTROL_RST 8'h00
`define LPM_POWER_CONTROL_WMASK 8'hDF
// port 1 mode select two fields
`define LPM_BIT_PUP 2
`define LPM_PORT1_MODE_SELECT_TWO_RST 8'h00
`define LPM_PORT1_MODE_SELECT_TWO_WMASK 8'h0F
// wake sources that act in power-down over the clocked path
`define LPM_PD_SYNC_MASK 7'h38
// bus answers
`define LPM_RESP_OKAY 2'h0
`define LPM_RESP_SLVERR 2'h2
`endif

// ===== verilog/lpm_pkg.sv
// lpm_pkg: types of the power-mode block
// assumes nothing beyond the constants header
package lpm_pkg;
	// interrupt sources, enabled sources wake the core
	typedef struct packed {
		logic other;
		logic brownout_detector;
		logic self_wakeup_timer;
		logic wdt;
		logic pin;
		logic ext1;
		logic ext0;
	} lpm_src_t;
	// reset requests from the reset unit
	typedef struct packed {
		logic pin_por;
		logic wdt;
		logic brownout_detector;
		logic sw;
	} lpm_rst_t;
	typedef enum logic [2:0] {ST_RUN, ST_IDLE, ST_PD, ST_WARM, ST_WAKE} lpm_state_t;
	typedef enum logic [1:0] {SEL_NONE, SEL_POWER_CONTROL, SEL_PORT1_MODE_SELECT_TWO, SEL_STAT} lpm_sel_t;
endpackage

// ===== verilog/lpm_ctrl.sv
// lpm_ctrl: idle and power-down sequencing, wake paths, pin pull-up control
// assumes cpu core, interrupt controller, oscillator and reset unit outside
//
// Summary of operation
// - idle bit stops cpu clock, holds pc, peripheral clocks keep running
// - power-down wake clears bit, runs waking isr, then resumes after entry
// - both bits set gives power-down only, never idle afterwards
// - the setting instruction is the last one executed before the mode
// - idle keeps cpu registers and port pin levels unchanged
// - any enabled interrupt request ends idle
// - every reset except software reset and brown-out reset with detection disabled ends idle
// - power-down stops flash, keeps ram and holds port pin values
// - non-software resets except brown-out with detection disabled end power-down; pin or power-on reset restarts cpu
// - brown-out reset wakes power-down only if detection was enabled
// - external trigger restarts clock asynchronously, isr waits for stability
// - only ext0, ext1, pin, watchdog, wake timer, brown-out wake power-down
// - pull-up bit controls pull-up when reset-pin option cleared, else on
`timescale 1ns/1ns
`default_nettype none
`include "lpm_consts.svh"
module lpm_ctrl (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic [11:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [11:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire lpm_pkg::lpm_src_t IRQ_REQ,
	input wire lpm_pkg::lpm_src_t IRQ_EN,
	input wire logic EXT_INT_ZERO_TRIG,
	input wire logic EXTERNAL_INTERRUPT_ONE,
	input wire logic PIN_INT_TRIG,
	input wire lpm_pkg::lpm_rst_t RST_REQ,
	input wire logic BROWNOUT_DETECTOR_EN,
	input wire logic OSC_STABLE,
	input wire logic RESET_PIN_DISABLE_OPTION,
	output logic CPU_CLK_EN,
	output logic PERIPH_CLK_EN,
	output logic PC_HOLD,
	output logic OSC_RUN,
	output logic FLASH_STOP,
	output logic PIN_HOLD,
	output logic WAKE_RESUME,
	output logic CPU_RESTART,
	output logic PULLUP_EN
);
	lpm_pkg::lpm_state_t st_q, st_d;
	logic [7:0] power_control_q, port1_mode_select_two_q;
	logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
	logic [11:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic wr_fire, ar_fire;
	lpm_pkg::lpm_sel_t wsel;
	logic wk_async_q, wk_s1, wk_s2, os_s1, os_s2, rpd_s1, rpd_s2;
	logic by_rst_q, resume_q, restart_q;
	logic qual_rst, irq_any, pd_wake, async_set;

	// address to register select, used by both bus paths
	function automatic lpm_pkg::lpm_sel_t lpm_sel(input logic [11:0] a);
		lpm_sel = lpm_pkg::SEL_NONE;
		if (a[1:0] == 2'h0) begin
			if (a[11:2] == `LPM_IDX_POWER_CONTROL)
				lpm_sel = lpm_pkg::SEL_POWER_CONTROL;
			else if (a[11:2] == `LPM_IDX_PORT1_MODE_SELECT_TWO)
				lpm_sel = lpm_pkg::SEL_PORT1_MODE_SELECT_TWO;
			else if (a[11:2] == `LPM_IDX_STAT)
				lpm_sel = lpm_pkg::SEL_STAT;
		end
	endfunction

	// write channel acceptance, either order
	assign S_AXI_AWREADY = !aw_got_q && !bvalid_q;
	assign S_AXI_WREADY = !w_got_q && !bvalid_q;
	assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
	assign wsel = lpm_sel(awaddr_q);
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;

	// latch address and data, answer once both are held
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 8'h00;
			wstrb_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `LPM_RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_got_q <= 1'b1;
				awaddr_q <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_got_q <= 1'b1;
				wdata_q <= S_AXI_WDATA[7:0];
				wstrb_q <= S_AXI_WSTRB[0];
			end
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= (wsel == lpm_pkg::SEL_NONE) ? `LPM_RESP_SLVERR : `LPM_RESP_OKAY;
			end else if (bvalid_q && S_AXI_BREADY) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read channel, one outstanding read
	assign S_AXI_ARREADY = !rvalid_q;
	assign ar_fire = S_AXI_ARVALID && !rvalid_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `LPM_RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_q <= 1'b1;
			rresp_q <= `LPM_RESP_OKAY;
			unique case (lpm_sel(S_AXI_ARADDR))
				lpm_pkg::SEL_POWER_CONTROL: rdata_q <= {24'h000000, power_control_q};
				lpm_pkg::SEL_PORT1_MODE_SELECT_TWO: rdata_q <= {24'h000000, port1_mode_select_two_q};
				lpm_pkg::SEL_STAT: rdata_q <= {27'h0000000, by_rst_q, os_s2,
					st_q == lpm_pkg::ST_WARM, st_q == lpm_pkg::ST_PD, st_q == lpm_pkg::ST_IDLE};
				lpm_pkg::SEL_NONE: begin
					rdata_q <= 32'h00000000;
					rresp_q <= `LPM_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && S_AXI_RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	// power control: software sets request bits, wake clears both
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			power_control_q <= `LPM_POWER_CONTROL_RST;
		end else if (wr_fire && wstrb_q && wsel == lpm_pkg::SEL_POWER_CONTROL) begin
			power_control_q <= wdata_q & `LPM_POWER_CONTROL_WMASK;
		end else if (st_q == lpm_pkg::ST_WAKE) begin
			power_control_q[`LPM_BIT_PD] <= 1'b0;
			power_control_q[`LPM_BIT_IDL] <= 1'b0;
		end
	end

	// port 1 mode select two
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			port1_mode_select_two_q <= `LPM_PORT1_MODE_SELECT_TWO_RST;
		else if (wr_fire && wstrb_q && wsel == lpm_pkg::SEL_PORT1_MODE_SELECT_TWO)
			port1_mode_select_two_q <= wdata_q & `LPM_PORT1_MODE_SELECT_TWO_WMASK;
	end

	assign async_set = (st_q == lpm_pkg::ST_PD) && ((EXT_INT_ZERO_TRIG && IRQ_EN.ext0)
		|| (EXTERNAL_INTERRUPT_ONE && IRQ_EN.ext1) || (PIN_INT_TRIG && IRQ_EN.pin));
	always_ff @(posedge REF_CLK or negedge RST_N or posedge async_set) begin
		if (!RST_N)
			wk_async_q <= 1'b0;
		else if (async_set)
			wk_async_q <= 1'b1;
		else if (st_q == lpm_pkg::ST_WAKE)
			wk_async_q <= 1'b0;
	end

	// synchronisers for latch, oscillator status and reset-pin option
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wk_s1 <= 1'b0;
			wk_s2 <= 1'b0;
			os_s1 <= 1'b0;
			os_s2 <= 1'b0;
			rpd_s1 <= 1'b1;
			rpd_s2 <= 1'b1;
		end else begin
			wk_s1 <= wk_async_q;
			wk_s2 <= wk_s1;
			os_s1 <= OSC_STABLE;
			os_s2 <= os_s1;
			rpd_s1 <= RESET_PIN_DISABLE_OPTION;
			rpd_s2 <= rpd_s1;
		end
	end

	assign qual_rst = RST_REQ.pin_por || RST_REQ.wdt || (RST_REQ.brownout_detector && BROWNOUT_DETECTOR_EN);
	assign irq_any = |(IRQ_REQ & IRQ_EN);
	assign pd_wake = wk_s2 || (|(IRQ_REQ & IRQ_EN & `LPM_PD_SYNC_MASK));

	// mode sequencer next state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			lpm_pkg::ST_RUN: begin
				if (power_control_q[`LPM_BIT_PD])
					st_d = lpm_pkg::ST_PD;
				else if (power_control_q[`LPM_BIT_IDL])
					st_d = lpm_pkg::ST_IDLE;
			end
			lpm_pkg::ST_IDLE: begin
				if (qual_rst || irq_any)
					st_d = lpm_pkg::ST_WAKE;
			end
			lpm_pkg::ST_PD: begin
				if (qual_rst || pd_wake)
					st_d = lpm_pkg::ST_WARM;
			end
			lpm_pkg::ST_WARM: begin
				if (os_s2)
					st_d = lpm_pkg::ST_WAKE;
			end
			lpm_pkg::ST_WAKE: st_d = lpm_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			st_q <= lpm_pkg::ST_RUN;
		else
			st_q <= st_d;
	end

	// wake cause and one-cycle resume or restart pulses
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			by_rst_q <= 1'b0;
			resume_q <= 1'b0;
			restart_q <= 1'b0;
		end else begin
			if (st_q == lpm_pkg::ST_RUN)
				by_rst_q <= 1'b0;
			else if (qual_rst && st_q != lpm_pkg::ST_WAKE)
				by_rst_q <= 1'b1;
			resume_q <= st_q == lpm_pkg::ST_WAKE && !by_rst_q;
			restart_q <= (st_q == lpm_pkg::ST_RUN && qual_rst) || (st_q == lpm_pkg::ST_WAKE && by_rst_q);
		end
	end

	// core stops right after the setting write
	assign CPU_CLK_EN = (st_q == lpm_pkg::ST_RUN && power_control_q[1:0] == 2'h0) || st_q == lpm_pkg::ST_WAKE;
	assign PC_HOLD = !CPU_CLK_EN;
	assign PERIPH_CLK_EN = !(st_q == lpm_pkg::ST_PD || st_q == lpm_pkg::ST_WARM
		|| (st_q == lpm_pkg::ST_RUN && power_control_q[`LPM_BIT_PD]));
	assign OSC_RUN = st_q != lpm_pkg::ST_PD || wk_async_q;
	assign FLASH_STOP = st_q == lpm_pkg::ST_PD || st_q == lpm_pkg::ST_WARM;
	assign PIN_HOLD = st_q == lpm_pkg::ST_IDLE || FLASH_STOP;
	assign WAKE_RESUME = resume_q;
	assign CPU_RESTART = restart_q;
	// pull-up forced on when pin is reset
	assign PULLUP_EN = rpd_s2 || port1_mode_select_two_q[`LPM_BIT_PUP];

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	idle_clk_gate_a: assert property (st_q == lpm_pkg::ST_IDLE |-> !CPU_CLK_EN && PERIPH_CLK_EN && PIN_HOLD)
		else $error("idle gating wrong");
	pd_clk_stop_a: assert property (st_q == lpm_pkg::ST_PD |-> !CPU_CLK_EN && !PERIPH_CLK_EN && FLASH_STOP)
		else $error("power-down gating wrong");
	pd_priority_a: assert property (st_q == lpm_pkg::ST_RUN && power_control_q[1:0] == 2'h3 |=> st_q == lpm_pkg::ST_PD)
		else $error("idle taken over power-down");
	last_insn_a: assert property ($rose(power_control_q[`LPM_BIT_IDL]) && st_q == lpm_pkg::ST_RUN |-> PC_HOLD)
		else $error("core ran past request");
	idle_exit_a: assert property (st_q == lpm_pkg::ST_IDLE && irq_any && !qual_rst |=> st_q == lpm_pkg::ST_WAKE ##1 WAKE_RESUME)
		else $error("idle not left on interrupt");
	wake_clear_a: assert property (st_q == lpm_pkg::ST_WAKE && !wr_fire |=> power_control_q[1:0] == 2'h0)
		else $error("request bits not cleared");
	sw_rst_a: assert property (st_q == lpm_pkg::ST_IDLE && !qual_rst && !irq_any |=> st_q == lpm_pkg::ST_IDLE)
		else $error("idle left without cause");
	pd_rst_a: assert property (st_q == lpm_pkg::ST_PD && qual_rst |=> st_q == lpm_pkg::ST_WARM && by_rst_q)
		else $error("reset did not end power-down");
	bod_gate_a: assert property (st_q == lpm_pkg::ST_PD && !qual_rst && !pd_wake |=> st_q == lpm_pkg::ST_PD)
		else $error("power-down left without source");
	pd_src_a: assert property (st_q == lpm_pkg::ST_PD && IRQ_REQ.other && !qual_rst && !pd_wake |=> FLASH_STOP)
		else $error("idle-only source woke power-down");
	warm_wait_a: assert property (st_q == lpm_pkg::ST_WARM && !os_s2 |=> !CPU_CLK_EN)
		else $error("core ran before oscillator stable");
	pd_resume_a: assert property (st_q == lpm_pkg::ST_WARM && os_s2 && !by_rst_q |=> ##1 WAKE_RESUME && !CPU_RESTART)
		else $error("no resume after power-down");
	async_sync_a: assert property ($rose(wk_async_q) |-> OSC_RUN ##2 wk_s2)
		else $error("clockless wake not synchronised");
	pullup_a: assert property (rpd_s2 |-> PULLUP_EN)
		else $error("pull-up off while pin is reset");
endmodule
`default_nettype wire

// ===== tb/tb.sv
// tb: self-checking bench for the power-mode control block
// assumes lpm_ctrl alone; the bench drives every input on the rising edge
`timescale 1ns/1ns
`default_nettype none
`include "lpm_consts.svh"
module tb;
	localparam logic [11:0] A_PC = {`LPM_IDX_POWER_CONTROL, 2'b00};
	localparam logic [11:0] A_PM = {`LPM_IDX_PORT1_MODE_SELECT_TWO, 2'b00};
	localparam logic [3:0] RTAB [5] = '{4'h1, 4'h2, 4'h2, 4'h4, 4'h8};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	lpm_pkg::lpm_src_t irq_req = '0, irq_en = '0;
	logic [2:0] trig = 3'h0;
	lpm_pkg::lpm_rst_t rst_req = '0;
	logic bod_en = 1'b0, osc_ok = 1'b1, rpin_opt = 1'b1;
	logic cpu_clk_en, periph_clk_en, pc_hold, osc_run, flash_stop, pin_hold, wake_resume, cpu_restart, pullup_en;
	int num_errors = 0, samples_checked = 0;
	logic [31:0] seed = 32'h00011156; // 69974

	lpm_ctrl i_dut (
		.REF_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.IRQ_REQ(irq_req), .IRQ_EN(irq_en), .EXT_INT_ZERO_TRIG(trig[0]), .EXTERNAL_INTERRUPT_ONE(trig[1]),
		.PIN_INT_TRIG(trig[2]), .RST_REQ(rst_req), .BROWNOUT_DETECTOR_EN(bod_en), .OSC_STABLE(osc_ok),
		.RESET_PIN_DISABLE_OPTION(rpin_opt), .CPU_CLK_EN(cpu_clk_en), .PERIPH_CLK_EN(periph_clk_en),
		.PC_HOLD(pc_hold), .OSC_RUN(osc_run), .FLASH_STOP(flash_stop), .PIN_HOLD(pin_hold),
		.WAKE_RESUME(wake_resume), .CPU_RESTART(cpu_restart), .PULLUP_EN(pullup_en)
	);

	// 25 MHz reference clock
	always #20 clk = ~clk;

	// xorshift source, fixed start
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// pull-up forced on while the pin acts as reset
	function automatic logic pull_exp(input logic opt, input logic [7:0] m);
		return opt | m[`LPM_BIT_PUP];
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one write; ready and response sampled at the falling edge, released after the next rising edge
	task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
		logic ah, wh, bh;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bh = 1'b0;
		while (!bh) begin
			@(negedge clk);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid;
			r = bresp;
			@(posedge clk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask

	// one read, same sampling scheme
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ah, rh;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rh = 1'b0;
		while (!rh) begin
			@(negedge clk);
			ah = arvalid & arready;
			rh = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ah) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask

	task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(what, exp, d);
		chk({what, " resp"}, {30'h0, er}, {30'h0, r});
	endtask

	// waits for either wake pulse, watchdog bounds it
	task automatic wait_wake(output logic w, output logic c);
		do @(negedge clk); while (wake_resume !== 1'b1 && cpu_restart !== 1'b1);
		w = wake_resume;
		c = cpu_restart;
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// watchdog well beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_sim();
	end

	initial begin
		logic [31:0] v;
		logic [1:0] resp;
		logic w, c;
		int k;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rdchk("power_control reset", A_PC, 32'h0, 2'h0);
		rdchk("port1_mode_select_two reset", A_PM, 32'h0, 2'h0);
		wr(12'h404, 8'hFF, resp);
		chk("unmapped wr", 32'h2, {30'h0, resp});
		rdchk("unmapped rd", 12'h404, 32'h0, 2'h2);
		for (int i = 0; i < 8; i++) begin
			v = rnd();
			if (i < 4) {v[8], v[2]} = i[1:0];
			wr(A_PM, v[7:0], resp);
			rpin_opt <= v[8];
			repeat (3) @(negedge clk);
			chk("pullup", {31'h0, pull_exp(v[8], v[7:0])}, {31'h0, pullup_en});
			rdchk("port1_mode_select_two", A_PM, {24'h0, v[7:0] & `LPM_PORT1_MODE_SELECT_TWO_WMASK}, 2'h0);
		end
		// idle entry and wake by a random source
		for (int i = 0; i < 4; i++) begin
			k = int'(rnd() % 7);
			wr(A_PC, 8'h01, resp);
			@(negedge clk);
			chk("idle gates", 32'h0E, {27'h0, cpu_clk_en, periph_clk_en, pc_hold, pin_hold, flash_stop});
			@(posedge clk);
			irq_req <= lpm_pkg::lpm_src_t'(7'h01 << k);
			irq_en <= lpm_pkg::lpm_src_t'(~(7'h01 << k));
			repeat (4) @(negedge clk);
			chk("idle masked", 32'h0, {31'h0, cpu_clk_en});
			@(posedge clk);
			irq_en <= lpm_pkg::lpm_src_t'(7'h7F);
			wait_wake(w, c);
			chk("idle wake", 32'h1, {31'h0, w});
			@(posedge clk);
			irq_req <= '0;
			rdchk("idle clear", A_PC, 32'h0, 2'h0);
		end
		// power-down with both bits, each wake path
		for (k = 0; k < 6; k++) begin
			v = rnd() | 32'h3;
			@(posedge clk);
			osc_ok <= 1'b0;
			wr(A_PC, v[7:0], resp);
			repeat (2) @(negedge clk);
			chk("pd gates", 32'h03, {27'h0, cpu_clk_en, periph_clk_en, osc_run, flash_stop, pin_hold});
			@(posedge clk);
			irq_req <= lpm_pkg::lpm_src_t'(7'h40);
			repeat (4) @(negedge clk);
			chk("pd other", 32'h0, {31'h0, osc_run});
			@(posedge clk);
			if (k < 3) trig <= 3'h1 << k;
			else irq_req <= lpm_pkg::lpm_src_t'(7'h01 << k);
			repeat (6) @(negedge clk);
			chk("pd warm", 32'h2, {30'h0, osc_run, cpu_clk_en});
			@(posedge clk);
			osc_ok <= 1'b1;
			wait_wake(w, c);
			chk("pd wake", 32'h1, {31'h0, w});
			@(posedge clk);
			trig <= 3'h0;
			irq_req <= '0;
			rdchk("pd clear", A_PC, {24'h0, v[7:0] & 8'hDC}, 2'h0);
			@(negedge clk);
			chk("no idle", 32'h1, {31'h0, cpu_clk_en});
		end
		// reset exits, software and unarmed brown-out refused
		for (int m = 1; m < 3; m++) begin
			for (int j = 0; j < 5; j++) begin
				wr(A_PC, m[7:0], resp);
				@(posedge clk);
				bod_en <= (j == 2);
				// watchdog kept running, so its reset arrives in idle or power-down
				rst_req <= lpm_pkg::lpm_rst_t'(RTAB[j]);
				@(posedge clk);
				rst_req <= '0;
				if (j < 2) begin
					repeat (5) @(negedge clk);
					chk("rst refused", 32'h0, {31'h0, cpu_clk_en});
					@(posedge clk);
					rst_req <= lpm_pkg::lpm_rst_t'(4'h8);
					@(posedge clk);
					rst_req <= '0;
				end
				wait_wake(w, c);
				chk("rst restart", 32'h1, {31'h0, c});
			end
		end
		end_sim();
	end
endmodule
`default_nettype wire
